// ---- core/rbs_defs.svh ----
// constants for the reset and boot sequencer
`ifndef RBS_DEFS_SVH
`define RBS_DEFS_SVH

// clock and reset-pin timing
`define RBS_CLK_PERIOD_NS 8
`define RBS_T_START_LO_NS 1000000
`define RBS_PULSE1_HI_MIN 17'h00032
`define RBS_PULSE1_HI_MAX 17'h00064
`define RBS_LO_MIN_CYC 17'h00064

// eprom boot
`define RBS_EPROM_WAITS 5'h10
`define RBS_BOOT_LAST_WORD 8'hff
`define RBS_BYTE_LAST 2'h3

// link receive dma defaults after reset
`define RBS_LINK_START 16'h0000
`define RBS_LINK_COUNT 9'h100
`define RBS_LINK_VECTOR 32'h0000_0000

// core start vectors
`define RBS_VEC_BOOT 32'h0000_0000
`define RBS_VEC_EXT 32'h3000_0000

// vector table entries enabled at reset: bit 0 dma0, 4..7 link rx, 8..11 ext irq
`define RBS_IVT_RESET_EN 32'h0000_0ff1

`endif

// ---- core/rbs_pkg.sv ----
// types shared by the reset and boot sequencer
`default_nettype none
package rbs_pkg;

   typedef enum logic [2:0] {
      ST_POR_LO = 3'h0,
      ST_POR_HI = 3'h1,
      ST_RESET = 3'h2,
      ST_EPROM = 3'h3,
      ST_IDLE = 3'h4,
      ST_RUN = 3'h5
   } rbs_state_e;

   // byte-wide eprom / flash pins
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic [23:0] addr;
      logic [7:0] wdata;
      logic data_oe;
   } rbs_eprom_s;

   // one link receive dma channel setup
   typedef struct packed {
      logic [15:0] start_addr;
      logic [8:0] count;
      logic int_en;
      logic [31:0] vector;
   } rbs_link_cfg_s;

endpackage

`default_nettype wire

// ---- core/rbs_span_counter.sv ----
// saturating counter of how long a level has held
`timescale 1ns/100ps
`default_nettype none

module rbs_span_counter #(
   parameter int W = 17
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // control
   input wire logic count_in,
   // result
   output logic [W-1:0] span_out
);

   // counts while the level holds, clears otherwise; saturates so long lows stay valid
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         span_out <= '0;
      end else if (!count_in) begin
         span_out <= '0;
      end else if (span_out != {W{1'b1}}) begin
         span_out <= span_out + 1'b1;
      end
   end

endmodule

`default_nettype wire

// ---- core/rbs_boot_seq.sv ----
// reset pin checking, core reset and boot path sequencing
`timescale 1ns/100ps
`default_nettype none
`include "rbs_defs.svh"

module rbs_boot_seq #(
   parameter int POR_LO_CYCLES = (`RBS_T_START_LO_NS + `RBS_CLK_PERIOD_NS - 1) / `RBS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // board pins
   input wire logic reset_pin_n_in,
   input wire logic test_reset_n_in,
   input wire logic boot_strap_in,
   input wire logic [3:0] external_interrupt_lines_in,
   // eprom / flash pins
   output logic boot_memory_select_out,
   output rbs_pkg::rbs_eprom_s eprom_out,
   input wire logic [7:0] eprom_data_in,
   // core side
   input wire logic core_soft_reset_bit_in,
   input wire logic [3:0] link_rx_done_in,
   output logic core_reset_out,
   output logic core_idle_out,
   output logic core_start_out,
   output logic [31:0] core_vector_out,
   output logic [31:0] ivt_enable_out,
   output rbs_pkg::rbs_link_cfg_s [3:0] link_cfg_out,
   // internal memory write port for boot words
   output logic imem_we_out,
   output logic [15:0] imem_addr_out,
   output logic [31:0] imem_data_out,
   // flash dma after boot
   input wire logic dma_req_in,
   input wire logic dma_write_in,
   input wire logic [23:0] dma_addr_in,
   input wire logic [7:0] dma_wdata_in,
   output logic dma_ack_out,
   output logic [7:0] dma_rdata_out,
   // reset pin pattern status
   output logic por_error_out,
   output logic boot_mode_eprom_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [14:0] sync1_reg;
   logic [14:0] sync2_reg;
   logic pin_d_reg;

   // first stage feeds only the second
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_reg <= 15'h0000;
         sync2_reg <= 15'h0000;
         pin_d_reg <= 1'b0;
      end else begin
         sync1_reg <= {external_interrupt_lines_in, eprom_data_in, boot_strap_in, test_reset_n_in, reset_pin_n_in};
         sync2_reg <= sync1_reg;
         pin_d_reg <= sync2_reg[0];
      end
   end

   wire pin_s = sync2_reg[0];
   wire trst_s = sync2_reg[1];
   wire strap_s = sync2_reg[2];
   wire [7:0] edata_s = sync2_reg[10:3];
   wire [3:0] irq_n_s = sync2_reg[14:11];
   wire pin_rise = pin_s & ~pin_d_reg;
   wire pin_fall = ~pin_s & pin_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // reset pin span measurement
   logic [16:0] lo_span;
   logic [16:0] hi_span;

   rbs_span_counter #(.W(17)) u_lo_span (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .count_in(~pin_s),
      .span_out(lo_span)
   );

   rbs_span_counter #(.W(17)) u_hi_span (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .count_in(pin_s),
      .span_out(hi_span)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequence decode
   rbs_pkg::rbs_state_e state_reg;
   rbs_pkg::rbs_state_e state_next;
   logic boot_mode_reg;
   logic boot_done_reg;
   logic acc_busy_reg;
   logic acc_done_reg;
   logic acc_we_reg;
   logic [4:0] acc_wait_reg;
   logic [7:0] boot_word_reg;
   logic [1:0] byte_idx_reg;
   logic [23:0] word_pack_reg;

   wire por_lo_ok = lo_span >= 17'(POR_LO_CYCLES);
   wire pulse_ok = (hi_span >= `RBS_PULSE1_HI_MIN) && (hi_span <= `RBS_PULSE1_HI_MAX);
   wire lo_ok = lo_span >= `RBS_LO_MIN_CYC;
   wire release_ok = (state_reg == rbs_pkg::ST_RESET) && pin_rise && lo_ok;
   wire running = (state_reg == rbs_pkg::ST_RUN);
   wire irq_any = ~&irq_n_s;
   wire link_any = |link_rx_done_in;
   wire soft_rst = core_soft_reset_bit_in && running;
   wire wake_boot = boot_done_reg && ivt_enable_out[0];
   wire wake_link = link_any && (|ivt_enable_out[7:4]);
   wire wake_irq = irq_any && (|ivt_enable_out[11:8]);
   wire wake = (state_reg == rbs_pkg::ST_IDLE) && (wake_boot || wake_link || wake_irq);
   wire por_bad = ((state_reg == rbs_pkg::ST_POR_LO) && ((pin_rise && !por_lo_ok) || trst_s)) ||
                  ((state_reg == rbs_pkg::ST_POR_HI) && pin_fall && !pulse_ok);

   // state transitions; a low pin after power-up always returns to reset
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rbs_pkg::ST_POR_LO: begin
            if (pin_rise && por_lo_ok) state_next = rbs_pkg::ST_POR_HI;
         end
         rbs_pkg::ST_POR_HI: begin
            if (pin_fall) state_next = pulse_ok ? rbs_pkg::ST_RESET : rbs_pkg::ST_POR_LO;
         end
         rbs_pkg::ST_RESET: begin
            if (release_ok) state_next = strap_s ? rbs_pkg::ST_IDLE : rbs_pkg::ST_EPROM;
         end
         rbs_pkg::ST_EPROM: begin
            if (pin_fall) state_next = rbs_pkg::ST_RESET;
            else if (boot_done_reg) state_next = rbs_pkg::ST_IDLE;
         end
         rbs_pkg::ST_IDLE: begin
            if (pin_fall) state_next = rbs_pkg::ST_RESET;
            else if (wake) state_next = rbs_pkg::ST_RUN;
         end
         rbs_pkg::ST_RUN: begin
            if (pin_fall) state_next = rbs_pkg::ST_RESET;
            else if (soft_rst) state_next = rbs_pkg::ST_IDLE;
         end
         default: state_next = rbs_pkg::ST_POR_LO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer, core control and reset-time setup
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= rbs_pkg::ST_POR_LO;
         boot_mode_reg <= 1'b0;
         por_error_out <= 1'b0;
         core_reset_out <= 1'b1;
         core_idle_out <= 1'b1;
         core_start_out <= 1'b0;
         core_vector_out <= `RBS_VEC_BOOT;
         ivt_enable_out <= `RBS_IVT_RESET_EN;
      end else begin
         state_reg <= state_next;
         if (release_ok) boot_mode_reg <= ~strap_s;
         if (por_bad) por_error_out <= 1'b1;
         else if (state_next == rbs_pkg::ST_RESET && state_reg == rbs_pkg::ST_POR_HI) por_error_out <= 1'b0;
         // core reset only; the access engine below is untouched
         core_reset_out <= (state_next == rbs_pkg::ST_POR_LO) || (state_next == rbs_pkg::ST_POR_HI) ||
                           (state_next == rbs_pkg::ST_RESET) || soft_rst;
         core_idle_out <= (state_next != rbs_pkg::ST_RUN);
         core_start_out <= wake;
         if (wake) core_vector_out <= wake_irq && !wake_boot && !wake_link ? `RBS_VEC_EXT : `RBS_VEC_BOOT;
         if (state_reg == rbs_pkg::ST_RESET) ivt_enable_out <= `RBS_IVT_RESET_EN;
      end
   end

   assign boot_mode_eprom_out = boot_mode_reg;

   // link receive dma defaults, rewritten on every pin reset; rst_in clears them and a soft reset keeps them
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_link
         always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
               link_cfg_out[gi] <= '0;
            end else if (state_reg == rbs_pkg::ST_RESET) begin
               link_cfg_out[gi].start_addr <= `RBS_LINK_START;
               link_cfg_out[gi].count <= `RBS_LINK_COUNT;
               link_cfg_out[gi].int_en <= 1'b1;
               link_cfg_out[gi].vector <= `RBS_LINK_VECTOR;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // byte access engine on dma channel 0: boot reads, then flash dma
   wire boot_go = (state_reg == rbs_pkg::ST_EPROM) && !boot_done_reg && !acc_busy_reg && !acc_done_reg;
   // a soft reset parks the core in idle, so flash dma must stay open there as well
   wire post_boot = running || (state_reg == rbs_pkg::ST_IDLE);
   wire dma_go = post_boot && dma_req_in && !acc_busy_reg && !acc_done_reg;
   wire acc_end = acc_busy_reg && (acc_wait_reg == `RBS_EPROM_WAITS);
   wire [23:0] boot_addr = {14'h0000, boot_word_reg, byte_idx_reg};
   wire boot_byte = acc_done_reg && (state_reg == rbs_pkg::ST_EPROM);

   // sixteen waits per access; chip select mirrors the busy flag
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         acc_busy_reg <= 1'b0;
         acc_done_reg <= 1'b0;
         acc_we_reg <= 1'b0;
         acc_wait_reg <= 5'h00;
         boot_memory_select_out <= 1'b1;
         eprom_out <= '{rd_n: 1'b1, wr_n: 1'b1, addr: 24'h000000, wdata: 8'h00, data_oe: 1'b0};
         dma_ack_out <= 1'b0;
         dma_rdata_out <= 8'h00;
      end else begin
         acc_done_reg <= acc_end;
         dma_ack_out <= acc_end && post_boot;
         if (boot_go || dma_go) begin
            acc_busy_reg <= 1'b1;
            acc_we_reg <= dma_go && dma_write_in;
            acc_wait_reg <= 5'h00;
            boot_memory_select_out <= 1'b0;
            eprom_out.addr <= boot_go ? boot_addr : dma_addr_in;
            eprom_out.rd_n <= dma_go && dma_write_in;
            eprom_out.wr_n <= !(dma_go && dma_write_in);
            eprom_out.data_oe <= dma_go && dma_write_in;
            eprom_out.wdata <= dma_wdata_in;
         end else if (acc_end || (acc_busy_reg && pin_fall)) begin
            acc_busy_reg <= 1'b0;
            boot_memory_select_out <= 1'b1;
            eprom_out.rd_n <= 1'b1;
            eprom_out.wr_n <= 1'b1;
            eprom_out.data_oe <= 1'b0;
            if (!acc_we_reg) dma_rdata_out <= edata_s;
         end else if (acc_busy_reg) begin
            acc_wait_reg <= acc_wait_reg + 5'h01;
         end
      end
   end

   // boot packing: first byte lands in the low lane of each word
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         boot_word_reg <= 8'h00;
         byte_idx_reg <= 2'h0;
         word_pack_reg <= 24'h000000;
         boot_done_reg <= 1'b0;
         imem_we_out <= 1'b0;
         imem_addr_out <= 16'h0000;
         imem_data_out <= 32'h0000_0000;
      end else begin
         imem_we_out <= 1'b0;
         if (state_reg == rbs_pkg::ST_RESET) begin
            boot_word_reg <= 8'h00;
            byte_idx_reg <= 2'h0;
            boot_done_reg <= 1'b0;
         end else if (state_reg == rbs_pkg::ST_IDLE && wake) begin
            boot_done_reg <= 1'b0;
         end else if (boot_byte) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
            word_pack_reg <= {dma_rdata_out, word_pack_reg[23:8]};
            if (byte_idx_reg == `RBS_BYTE_LAST) begin
               imem_we_out <= 1'b1;
               imem_addr_out <= {8'h00, boot_word_reg};
               imem_data_out <= {dma_rdata_out, word_pack_reg};
               boot_word_reg <= boot_word_reg + 8'h01;
               if (boot_word_reg == `RBS_BOOT_LAST_WORD) boot_done_reg <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // length of each access, counted here so the wait check needs no long repetition
   logic [4:0] chk_busy_len_reg;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         chk_busy_len_reg <= 5'h00;
      end else if (acc_busy_reg) begin
         chk_busy_len_reg <= chk_busy_len_reg + 5'h01;
      end else begin
         chk_busy_len_reg <= 5'h00;
      end
   end

   // an access starting or ending in the same cycle changes busy for its own reason
   property p_soft;
      soft_rst && !dma_go && !acc_end && !pin_fall |=> core_reset_out && core_idle_out && $stable(acc_busy_reg);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset disturbed the access engine");

   property p_strap;
      release_ok && !strap_s |=> state_reg == rbs_pkg::ST_EPROM && boot_mode_reg;
   endproperty
   a_strap: assert property (p_strap) else $error("low strap did not select eprom boot");

   property p_waits;
      $fell(acc_busy_reg) && !$past(pin_fall) |-> acc_done_reg && $past(chk_busy_len_reg) == `RBS_EPROM_WAITS;
   endproperty
   a_waits: assert property (p_waits) else $error("access did not last sixteen waits");

   property p_cs;
      acc_busy_reg == !boot_memory_select_out;
   endproperty
   a_cs: assert property (p_cs) else $error("chip select out of step with access");

   property p_pack;
      imem_we_out |-> $past(byte_idx_reg) == `RBS_BYTE_LAST && imem_data_out[31:24] == $past(dma_rdata_out);
   endproperty
   a_pack: assert property (p_pack) else $error("boot word written before four bytes");

   property p_dma;
      dma_go |=> acc_busy_reg && eprom_out.addr == $past(dma_addr_in) && eprom_out.wr_n == !$past(dma_write_in);
   endproperty
   a_dma: assert property (p_dma) else $error("flash dma access not started");

   property p_link;
      $fell(state_reg == rbs_pkg::ST_RESET) |-> link_cfg_out[0].count == `RBS_LINK_COUNT &&
         link_cfg_out[3].vector == `RBS_LINK_VECTOR && link_cfg_out[2].int_en;
   endproperty
   a_link: assert property (p_link) else $error("link dma defaults missing after reset");

   property p_irq;
      state_reg == rbs_pkg::ST_IDLE && irq_any && !boot_done_reg && !link_any && !pin_fall |=>
         core_start_out && core_vector_out == `RBS_VEC_EXT && state_reg == rbs_pkg::ST_RUN;
   endproperty
   a_irq: assert property (p_irq) else $error("external interrupt did not start core");

   property p_idle;
      $fell(core_reset_out) |-> core_idle_out;
   endproperty
   a_idle: assert property (p_idle) else $error("core left reset without idling");

   property p_mode;
      state_reg != rbs_pkg::ST_RESET |=> $stable(boot_mode_reg);
   endproperty
   a_mode: assert property (p_mode) else $error("boot mode changed outside reset");

endmodule

`default_nettype wire

// ---- test/rbs_board_model.sv ----
// board reset logic and byte-wide eprom/flash model for the boot sequencer
`timescale 1ns/100ps
`default_nettype none

module rbs_board_model (
   // clock
   input wire logic clock_in,
   // eprom pins from the device
   input wire logic cs_n_in,
   input wire rbs_pkg::rbs_eprom_s eprom_in,
   // eprom data and board reset pins
   output logic [7:0] data_out,
   output logic reset_pin_n_out,
   output logic test_reset_n_out,
   // last flash write seen
   output logic [23:0] wr_addr_out,
   output logic [7:0] wr_data_out
);
   // image byte at an address; upper bits mixed in so byte order errors show
   function automatic logic [7:0] bval(input logic [23:0] a);
      return a[7:0] ^ {4{a[9:8]}};
   endfunction

   initial begin
      data_out = 8'h00;
      reset_pin_n_out = 1'b0;
      test_reset_n_out = 1'b0;
      wr_addr_out = 24'h000000;
      wr_data_out = 8'h00;
   end

   // data only while selected and read; otherwise a toggling pattern, no pull
   always @(posedge clock_in) begin
      if (!cs_n_in && !eprom_in.rd_n) begin
         data_out <= bval(eprom_in.addr);
      end else begin
         data_out <= ~data_out;
      end
      if (!cs_n_in && !eprom_in.wr_n && eprom_in.data_oe) begin
         wr_addr_out <= eprom_in.addr;
         wr_data_out <= eprom_in.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-up pattern; hi outside 50..100 only when a scenario asks for it
   task automatic power_up(input int lo, input int hi);
      test_reset_n_out = 1'b0;
      reset_pin_n_out = 1'b0;
      repeat (lo) @(negedge clock_in);
      reset_pin_n_out = 1'b1;
      repeat (hi) @(negedge clock_in);
      reset_pin_n_out = 1'b0;
      repeat (110) @(negedge clock_in);
      reset_pin_n_out = 1'b1;
      test_reset_n_out = 1'b1;
   endtask

   // later reset; lo below 100 only when a scenario asks for it
   task automatic pin_reset(input int lo);
      reset_pin_n_out = 1'b0;
      repeat (lo) @(negedge clock_in);
      reset_pin_n_out = 1'b1;
   endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking testbench for the reset and boot sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clock_in, rst_in, test_reset_n, reset_pin_n, boot_strap_in, soft_in;
   logic [3:0] irq_n, link_done;
   logic [7:0] eprom_data, dma_wdata, rdata;
   logic dma_req, dma_write, cs_n, core_reset, core_idle, core_start, imem_we, dma_ack, por_error, boot_mode;
   logic [23:0] dma_addr;
   logic [31:0] core_vector, ivt_enable, imem_data;
   logic [15:0] imem_addr;
   logic [7:0] dma_rdata;
   rbs_pkg::rbs_eprom_s eprom;
   rbs_pkg::rbs_link_cfg_s [3:0] link_cfg;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;

   rbs_boot_seq #(.POR_LO_CYCLES(200)) dut_u (.clock_in(clock_in), .rst_in(rst_in),
      .reset_pin_n_in(reset_pin_n), .test_reset_n_in(test_reset_n), .boot_strap_in(boot_strap_in),
      .external_interrupt_lines_in(irq_n), .boot_memory_select_out(cs_n), .eprom_out(eprom),
      .eprom_data_in(eprom_data), .core_soft_reset_bit_in(soft_in), .link_rx_done_in(link_done),
      .core_reset_out(core_reset), .core_idle_out(core_idle), .core_start_out(core_start),
      .core_vector_out(core_vector), .ivt_enable_out(ivt_enable), .link_cfg_out(link_cfg),
      .imem_we_out(imem_we), .imem_addr_out(imem_addr), .imem_data_out(imem_data),
      .dma_req_in(dma_req), .dma_write_in(dma_write), .dma_addr_in(dma_addr), .dma_wdata_in(dma_wdata),
      .dma_ack_out(dma_ack), .dma_rdata_out(dma_rdata), .por_error_out(por_error),
      .boot_mode_eprom_out(boot_mode));

   rbs_board_model board_u (.clock_in(clock_in), .cs_n_in(cs_n), .eprom_in(eprom), .data_out(eprom_data),
      .reset_pin_n_out(reset_pin_n), .test_reset_n_out(test_reset_n), .wr_addr_out(), .wr_data_out());

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   // hang guard, well above the eprom boot length
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // holds the request until the ack, as the flash dma requester must
   task automatic dma_op(input logic wr, input logic [23:0] a, input logic [7:0] d);
      int n;
      dma_req = 1'b1;
      dma_write = wr;
      dma_addr = a;
      dma_wdata = d;
      for (n = 0; n < 40 && dma_ack !== 1'b1; n++) @(negedge clock_in);
      rdata = dma_rdata;
      check("dma ack", 1, dma_ack);
      // keep the request over the edge that samples the ack
      @(negedge clock_in);
      dma_req = 1'b0;
      @(negedge clock_in);
   endtask

   task automatic wait_start();
      int n;
      for (n = 0; n < 12 && core_start !== 1'b1; n++) @(negedge clock_in);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_por_bad();
      board_u.power_up(210, 30);
      repeat (4) @(negedge clock_in);
      check("por_error", 1, por_error);
      check("core_reset held", 1, core_reset);
      $display("test por_bad done");
   endtask

   task automatic t_boot_eprom();
      int n, low, words;
      boot_strap_in = 1'b0;
      board_u.power_up(210, 70);
      for (n = 0; n < 10 && core_reset !== 1'b0; n++) @(negedge clock_in);
      boot_strap_in = 1'b1; // strap moves after release and must not count
      check("core_reset", 0, core_reset);
      check("por_error", 0, por_error);
      check("boot_mode", 1, boot_mode);
      check("idle", 1, core_idle);
      check("ivt", 32'h0000_0ff1, ivt_enable);
      for (n = 0; n < 4; n++) check("link_cfg", {16'h0000, 9'h100, 1'b1, 32'h0}, link_cfg[n]);
      for (n = 0; n < 5 && cs_n !== 1'b0; n++) @(negedge clock_in);
      check("first read", {1'b0, 1'b1, 24'h000000}, {eprom.rd_n, eprom.wr_n, eprom.addr});
      for (low = 0; low < 30 && cs_n === 1'b0; low++) @(negedge clock_in);
      check("cs low cycles", 17, low);
      words = 0;
      for (n = 0; n < 25000 && core_start !== 1'b1; n++) begin
         if (imem_we === 1'b1) begin
            check("imem addr", words, imem_addr);
            check("imem data", {board_u.bval(4*words+3), board_u.bval(4*words+2),
               board_u.bval(4*words+1), board_u.bval(4*words)}, imem_data);
            words++;
         end
         @(negedge clock_in);
      end
      check("words", 256, words);
      check("start", 1, core_start);
      check("vector", 0, core_vector);
      check("boot_mode held", 1, boot_mode);
      $display("test boot_eprom done");
   endtask

   task automatic t_flash_dma();
      dma_op(1'b0, 24'hfffffd, 8'h00);
      check("dma rdata", board_u.bval(24'hfffffd), rdata);
      dma_op(1'b1, 24'hfffffe, 8'ha5);
      check("flash write", {24'hfffffe, 8'ha5}, {board_u.wr_addr_out, board_u.wr_data_out});
      check("cs released", 1, cs_n);
      $display("test flash_dma done");
   endtask

   task automatic t_soft_reset();
      int n;
      soft_in = 1'b1;
      for (n = 0; n < 10 && core_idle !== 1'b1; n++) @(negedge clock_in);
      check("soft idle", 1, core_idle);
      dma_op(1'b0, 24'h000123, 8'h00);
      check("dma in soft reset", board_u.bval(24'h000123), rdata);
      soft_in = 1'b0;
      check("mode kept", 1, boot_mode);
      $display("test soft_reset done");
   endtask

   // no-boot wake from each interrupt line, or from each link channel when by_link is set
   task automatic t_wake(input bit by_link);
      int i, n;
      for (i = 0; i < 4; i++) begin
         if (i == 0) begin
            board_u.pin_reset(40);
            repeat (10) @(negedge clock_in);
            check("short reset held", 1, core_reset);
         end
         board_u.pin_reset(120);
         for (n = 0; n < 10 && core_reset !== 1'b0; n++) @(negedge clock_in);
         boot_strap_in = 1'b0;
         repeat (30) @(negedge clock_in);
         check("no boot", {1'b0, 1'b1, 1'b1, 1'b0}, {boot_mode, cs_n, core_idle, core_start});
         if (by_link) begin
            link_done[i] = 1'b1;
            @(negedge clock_in);
            link_done[i] = 1'b0;
         end else begin
            irq_n[i] = 1'b0;
         end
         wait_start();
         check("wake", 1, core_start);
         check("wake vector", by_link ? 32'h0 : 32'h3000_0000, core_vector);
         irq_n = 4'hf;
         boot_strap_in = 1'b1;
         @(negedge clock_in);
      end
      $display("test wake done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_in = 1'b1;
      boot_strap_in = 1'b1;
      soft_in = 1'b0;
      irq_n = 4'hf;
      link_done = 4'h0;
      dma_req = 1'b0;
      dma_write = 1'b0;
      dma_addr = 24'h000000;
      dma_wdata = 8'h00;
      repeat (5) @(negedge clock_in);
      check("reset outs", {1'b1, 1'b1, 1'b1, 32'h0000_0ff1}, {cs_n, core_reset, core_idle, ivt_enable});
      rst_in = 1'b0;
      t_por_bad();
      t_boot_eprom();
      t_flash_dma();
      t_soft_reset();
      t_wake(1'b0);
      t_wake(1'b1);
      finish_test();
   end
endmodule

`default_nettype wire
